/* File: sim/host_model.sv */
module host_model
  import rx1_loss_pkg::*;
(
  // Clock and read data.
  input wire logic mclk,
  input wire logic [7:0] host_rdata,
  // Request toward the bank.
  output host_req_type host_req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial host_req = '0;
  // One byte per call; afterwards address and data are inverted so no stale value lingers.
  task automatic access_byte(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(negedge mclk);
    host_req = '{!w, w, a, d};
    @(negedge mclk);
    host_req = '{1'b0, 1'b0, ~a, ~d};
    q = host_rdata;
  endtask
endmodule

/* File: sim/rx1_loss_monitor.sv */
module rx1_loss_monitor
  import rx1_loss_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Host side.
  input wire host_req_type host_req,
  input wire logic [7:0] host_rdata,
  input wire logic host_hit,
  input wire access_type access,
  input wire logic fast_trip_enable,
  // Comparator side.
  input wire logic [LEVEL_WIDTH-1:0] rx1_signal_strength_input,
  input wire logic rx1_signal_loss_low,
  input wire logic rx1_signal_loss_high,
  input wire logic [LEVEL_WIDTH-1:0] upper_level,
  input wire logic [LEVEL_WIDTH-1:0] lower_level
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // Permission terms and short aliases.
  wire logic l1 = access.level1_password;
  wire logic w_ok = access.level2_password | l1 & access.cfg_page_rw_permit;
  wire logic r_ok = w_ok | l1 & access.cfg_page_read_permit;
  wire logic [LEVEL_WIDTH-1:0] smp = rx1_signal_strength_input;
  wire logic lo = rx1_signal_loss_low;
  wire logic hi = rx1_signal_loss_high;
  // A write that must be ignored, after a cycle with no write.
  sequence calm_then_refused;
    !host_req.wr ##1 host_req.wr && (!w_ok || fast_trip_enable && host_req.addr != 8'hbc);
  endsequence
  // Low alarm standing while the sample climbs past the upper level.
  sequence climbs_out;
    lo && smp > upper_level;
  endsequence
  hit_decode_a: assert property (host_hit == (host_req.addr[7:2] == 6'h2f))
    else $error("bad hit decode");
  read_denied_a: assert property (host_req.rd && !r_ok |=> host_rdata == 8'h00)
    else $error("denied read gave data");
  gap_read_a: assert property (host_req.rd && host_req.addr == 8'hbd |=> !(|host_rdata))
    else $error("gap byte not zero");
  range_spare_a: assert property (host_req.rd && host_req.addr == 8'hbc |=>
    host_rdata[7] == 1'b0 && host_rdata[3] == 1'b0) else $error("spare bits set");
  refused_hold_a: assert property (calm_then_refused |=>
    $stable(upper_level) && $stable(lower_level)) else $error("refused write took effect");
  low_set_a: assert property (smp < lower_level |=> lo && !hi)
    else $error("low alarm not set");
  high_set_a: assert property (climbs_out |=> !lo && hi)
    else $error("high alarm not set");
  low_hold_a: assert property (lo && smp <= upper_level |=> lo)
    else $error("low alarm dropped early");
endmodule

bind rx1_loss_regs rx1_loss_monitor mon (.mclk, .rst_n, .host_req, .host_rdata, .host_hit,
  .access, .fast_trip_enable, .rx1_signal_strength_input, .rx1_signal_loss_low,
  .rx1_signal_loss_high, .upper_level, .lower_level);

/* File: sim/testbench.sv */
module testbench
  import rx1_loss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int scale [8] = '{SCALE_CODE0, SCALE_CODE1, SCALE_CODE2, SCALE_CODE3,
    SCALE_CODE4, SCALE_CODE5, SCALE_CODE6, SCALE_CODE7};
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic fast_trip_enable = 1'b0;
  access_type access = 4'h4;
  logic [LEVEL_WIDTH-1:0] rx1_signal_strength_input = '0;
  host_req_type host_req;
  logic [7:0] host_rdata, rb;
  logic host_hit, rx1_signal_loss_low, rx1_signal_loss_high;
  logic [LEVEL_WIDTH-1:0] upper_level, lower_level;
  int failures = 0;
  int num_checks = 0;
  always #5 mclk = ~mclk;
  host_model host (.mclk, .host_rdata, .host_req);
  rx1_loss_regs DUT (.mclk, .rst_n, .host_req, .host_rdata, .host_hit, .access,
    .fast_trip_enable, .rx1_signal_strength_input, .rx1_signal_loss_low,
    .rx1_signal_loss_high, .upper_level, .lower_level);
  // Compares one value and counts the outcome.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Byte access helpers.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.access_byte(1'b1, a, d, rb);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    host.access_byte(1'b0, a, 8'h00, rb);
    check(32'(rb), 32'(e));
  endtask
  task automatic reset_values;
    rd_chk(8'hbc, 8'h00);
    rd_chk(8'hbd, 8'h00);
    rd_chk(8'hbe, 8'h00);
    rd_chk(8'hbf, 8'h00);
    check(32'(host_hit), 32'(0));
  endtask
  // Ranging writes pass with fast trip on; each code pair scales both levels.
  task automatic range_walk;
    fast_trip_enable = 1'b1;
    wr(8'hbc, 8'hff);
    rd_chk(8'hbc, 8'h77);
    fast_trip_enable = 1'b0;
    wr(8'hbd, 8'hff);
    rd_chk(8'hbd, 8'h00);
    wr(8'hbe, 8'd20);
    wr(8'hbf, 8'd10);
    for (int c = 0; c < 8; c++) begin
      wr(8'hbc, {1'b1, 3'(c), 1'b1, 3'(7 - c)});
      @(negedge mclk);
      check(32'(upper_level), 20 * scale[c]);
      check(32'(lower_level), 10 * scale[7 - c]);
    end
    wr(8'hbc, 8'h00);
  endtask
  // Every password, permission and fast trip mix against one threshold byte.
  task automatic perm_table;
    logic [7:0] cur;
    logic w, r;
    cur = 8'd20;
    for (int j = 0; j < 32; j++) begin
      access = 4'(j);
      fast_trip_enable = j[4];
      w = j[2] | j[3] & j[1];
      r = w | j[3] & j[0];
      wr(8'hbe, 8'(j + 32));
      if (w && !j[4]) cur = 8'(j + 32);
      rd_chk(8'hbe, r ? cur : 8'h00);
    end
    access = 4'h4;
    fast_trip_enable = 1'b0;
    wr(8'hbe, 8'd20);
  endtask
  // Sample starts below the lower level, climbs past the upper level, and falls back below the lower.
  task automatic alarm_walk;
    int lvl [5] = '{5, 15, 25, 15, 5};
    logic [1:0] exp [5] = '{2'b10, 2'b10, 2'b01, 2'b01, 2'b10};
    for (int i = 0; i < 5; i++) begin
      rx1_signal_strength_input = 22'(lvl[i] * scale[0]);
      @(negedge mclk);
      check(32'({rx1_signal_loss_low, rx1_signal_loss_high}), 32'(exp[i]));
    end
  endtask
  initial begin
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    reset_values();
    range_walk();
    perm_table();
    alarm_walk();
    report_and_stop();
  end
  // Hang guard.
  initial begin
    #100us;
    failures++;
    report_and_stop();
  end
endmodule

/* File: verilog/rx1_loss_compare.sv */
module rx1_loss_compare
  import rx1_loss_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Comparison levels and sampled input.
  input wire logic [LEVEL_WIDTH-1:0] upper_level,
  input wire logic [LEVEL_WIDTH-1:0] lower_level,
  input wire logic [LEVEL_WIDTH-1:0] sample_level,
  // Alarm bits.
  output logic rx1_signal_loss_low,
  output logic rx1_signal_loss_high
);

  alarm_state_type state_reg;
  alarm_state_type state_next;

  // Low alarm is raised below the lower level and held until above the upper.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ALARM_IDLE, ALARM_HIGH: begin
        if (sample_level < lower_level) begin
          state_next = ALARM_LOW;
        end
      end
      ALARM_LOW: begin
        if (sample_level > upper_level) begin
          state_next = ALARM_HIGH;
        end
      end
      default: begin
        state_next = ALARM_IDLE;
      end
    endcase
  end

  // Alarm state register.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_reg <= ALARM_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Alarm outputs come straight from the state flops.
  assign rx1_signal_loss_low = (state_reg == ALARM_LOW);
  assign rx1_signal_loss_high = (state_reg == ALARM_HIGH);

endmodule

/* File: verilog/rx1_loss_pkg.sv */
package rx1_loss_pkg;

  // Register offsets inside the configuration page.
  localparam logic [7:0] RANGE_SELECT_OFFSET = 8'hbc;
  localparam logic [7:0] RESERVED_GAP_OFFSET = 8'hbd;
  localparam logic [7:0] UPPER_THRESHOLD_OFFSET = 8'hbe;
  localparam logic [7:0] LOWER_THRESHOLD_OFFSET = 8'hbf;

  // Field positions in the ranging byte.
  localparam int UPPER_RANGE_MSB = 6;
  localparam int UPPER_RANGE_LSB = 4;
  localparam int LOWER_RANGE_MSB = 2;
  localparam int LOWER_RANGE_LSB = 0;
  localparam logic [7:0] RANGE_WRITE_MASK = 8'h77;

  // Reset values.
  localparam logic [7:0] RANGE_SELECT_RESET = 8'h00;
  localparam logic [7:0] RESERVED_GAP_RESET = 8'h00;
  localparam logic [7:0] UPPER_THRESHOLD_RESET = 8'h00;
  localparam logic [7:0] LOWER_THRESHOLD_RESET = 8'h00;

  // Full-scale per range code, in units of 0.01 percent of 1.25 V.
  localparam logic [13:0] SCALE_CODE0 = 14'd10000;
  localparam logic [13:0] SCALE_CODE1 = 14'd8002;
  localparam logic [13:0] SCALE_CODE2 = 14'd6669;
  localparam logic [13:0] SCALE_CODE3 = 14'd5005;
  localparam logic [13:0] SCALE_CODE4 = 14'd4005;
  localparam logic [13:0] SCALE_CODE5 = 14'd3338;
  localparam logic [13:0] SCALE_CODE6 = 14'd2862;
  localparam logic [13:0] SCALE_CODE7 = 14'd2504;

  // Signal strength sample: threshold code at full scale times scale.
  localparam int LEVEL_WIDTH = 22;

  // Host access request toward the register bank.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } host_req_type;

  // Security state supplied by the password logic.
  typedef struct packed {
    logic level1_password;
    logic level2_password;
    logic cfg_page_rw_permit;
    logic cfg_page_read_permit;
  } access_type;

  // Alarm states of the hysteresis comparator.
  typedef enum logic [1:0] {
    ALARM_IDLE = 2'b00,
    ALARM_LOW = 2'b01,
    ALARM_HIGH = 2'b10
  } alarm_state_type;

endpackage

/* File: verilog/rx1_loss_regs.sv */
module rx1_loss_regs
  import rx1_loss_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Host access from the serial memory engine.
  input wire host_req_type host_req,
  output logic [7:0] host_rdata,
  output logic host_hit,
  // Security and quick-trip state.
  input wire access_type access,
  input wire logic fast_trip_enable,
  // Signal strength sample from the converter, full scale per range.
  input wire logic [LEVEL_WIDTH-1:0] rx1_signal_strength_input,
  // Alarm bits and configured levels.
  output logic rx1_signal_loss_low,
  output logic rx1_signal_loss_high,
  output logic [LEVEL_WIDTH-1:0] upper_level,
  output logic [LEVEL_WIDTH-1:0] lower_level
);

  logic [7:0] range_reg;
  logic [7:0] range_next;
  logic [7:0] upper_reg;
  logic [7:0] upper_next;
  logic [7:0] lower_reg;
  logic [7:0] lower_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic read_ok;
  logic write_ok;
  logic thresh_write_ok;
  logic [LEVEL_WIDTH-1:0] upper_level_reg;
  logic [LEVEL_WIDTH-1:0] upper_level_next;
  logic [LEVEL_WIDTH-1:0] lower_level_reg;
  logic [LEVEL_WIDTH-1:0] lower_level_next;

  // Map a range code to its full-scale factor.
  function automatic logic [13:0] scale_of(input logic [2:0] code);
    logic [13:0] s;
    s = SCALE_CODE0;
    case (code)
      3'h0: s = SCALE_CODE0;
      3'h1: s = SCALE_CODE1;
      3'h2: s = SCALE_CODE2;
      3'h3: s = SCALE_CODE3;
      3'h4: s = SCALE_CODE4;
      3'h5: s = SCALE_CODE5;
      3'h6: s = SCALE_CODE6;
      3'h7: s = SCALE_CODE7;
      default: s = SCALE_CODE0;
    endcase
    return s;
  endfunction

  // Linear level: threshold code times selected full-scale factor.
  function automatic logic [LEVEL_WIDTH-1:0] level_of(input logic [7:0] code,
                                                      input logic [2:0] range);
    // Both operands are widened first so the product keeps all of its bits.
    return LEVEL_WIDTH'(code) * LEVEL_WIDTH'(scale_of(range));
  endfunction

  // Permission decode from the password state.
  always_comb begin
    read_ok = access.level2_password
              | (access.level1_password & access.cfg_page_rw_permit)
              | (access.level1_password & access.cfg_page_read_permit);
    write_ok = access.level2_password
               | (access.level1_password & access.cfg_page_rw_permit);
    thresh_write_ok = write_ok & ~fast_trip_enable;
  end

  // Register next values; refused writes simply keep the old value.
  always_comb begin
    range_next = range_reg;
    upper_next = upper_reg;
    lower_next = lower_reg;
    if (host_req.wr) begin
      case (host_req.addr)
        RANGE_SELECT_OFFSET: begin
          if (write_ok) begin
            range_next = host_req.wdata & RANGE_WRITE_MASK;
          end
        end
        UPPER_THRESHOLD_OFFSET: begin
          if (thresh_write_ok) begin
            upper_next = host_req.wdata;
          end
        end
        LOWER_THRESHOLD_OFFSET: begin
          if (thresh_write_ok) begin
            lower_next = host_req.wdata;
          end
        end
        default: begin
          range_next = range_reg;
        end
      endcase
    end
  end

  // Storage registers; reset loads the package reset values.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      range_reg <= RANGE_SELECT_RESET;
      upper_reg <= UPPER_THRESHOLD_RESET;
      lower_reg <= LOWER_THRESHOLD_RESET;
    end else begin
      range_reg <= range_next;
      upper_reg <= upper_next;
      lower_reg <= lower_next;
    end
  end

  // Read data; denied reads and the reserved byte return zero.
  always_comb begin
    rdata_next = 8'h00;
    if (host_req.rd && read_ok) begin
      case (host_req.addr)
        RANGE_SELECT_OFFSET: rdata_next = range_reg;
        RESERVED_GAP_OFFSET: rdata_next = RESERVED_GAP_RESET;
        UPPER_THRESHOLD_OFFSET: rdata_next = upper_reg;
        LOWER_THRESHOLD_OFFSET: rdata_next = lower_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // Comparison levels from threshold codes and range fields.
  always_comb begin
    upper_level_next = level_of(upper_reg,
      range_reg[UPPER_RANGE_MSB:UPPER_RANGE_LSB]);
    lower_level_next = level_of(lower_reg,
      range_reg[LOWER_RANGE_MSB:LOWER_RANGE_LSB]);
  end

  // Read data and levels are registered.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
      upper_level_reg <= '0;
      lower_level_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
      upper_level_reg <= upper_level_next;
      lower_level_reg <= lower_level_next;
    end
  end

  // The bank claims its four addresses; the transaction is never stalled.
  assign host_hit = (host_req.addr[7:2] == RANGE_SELECT_OFFSET[7:2]);
  assign host_rdata = rdata_reg;
  assign upper_level = upper_level_reg;
  assign lower_level = lower_level_reg;

  // Hysteresis comparator on the sampled signal strength.
  rx1_loss_compare u_compare (
    .mclk(mclk),
    .rst_n(rst_n),
    .upper_level(upper_level_reg),
    .lower_level(lower_level_reg),
    .sample_level(rx1_signal_strength_input),
    .rx1_signal_loss_low(rx1_signal_loss_low),
    .rx1_signal_loss_high(rx1_signal_loss_high)
  );

endmodule
